// File: fault_panel_pkg.sv
package fault_panel_pkg;

  // Panel geometry.
  localparam int          NUM_SLOTS   = 9;
  localparam int          TT_SLOT     = 9;   // Index of display number 10.
  localparam int          SYS_W       = 5;
  localparam int          CODE_W      = 14;  // System letter plus 3 octal digits.
  localparam logic [3:0]  DIGITS      = 4'h3;

  // Host exchange outcomes.
  localparam logic [1:0]  ANS_INVALID = 2'h0;
  localparam logic [1:0]  ANS_ACTIVE  = 2'h1;
  localparam logic [1:0]  ANS_NEW     = 2'h2;

  // Host operations.
  localparam logic [1:0]  OP_ACTIVATE = 2'h0;
  localparam logic [1:0]  OP_CLEAR    = 2'h1;
  localparam logic [1:0]  OP_CLR_ALL  = 2'h2;

  // Time-tagged lamp flash rate.
  localparam int          CLK_MHZ     = 250;
  localparam int          FLASH_MS    = 250;
  localparam int          FLASH_CYC   = FLASH_MS * 1000 * CLK_MHZ;

  // Register offsets of the APB slave.
  localparam logic [7:0]  OFS_STATUS  = 8'h00;
  localparam logic [7:0]  OFS_CTRL    = 8'h04;
  localparam logic [7:0]  OFS_PEND    = 8'h08;
  localparam logic [7:0]  OFS_ENTD    = 8'h0C;
  localparam logic        CTRL_RST    = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SYSTEM  = 3'h1,
    ST_DIGITS  = 3'h2,
    ST_QUERY   = 3'h3,
    ST_OPER    = 3'h4,
    ST_HOSTOP  = 3'h5,
    ST_INVALID = 3'h6,
    ST_CLRALL  = 3'h7
  } state_t;

endpackage

// File: fault_insertion_unit.sv
// What this block does
// - Nine selectable slots, slot ten reserved.
// - Selection lights slot lamp and in-use lamp.
// - System switch picks letter, stays lit.
// - Three octal digits echoed into verify.
// - Third digit queries host, three outcomes.
// - Invalid lights lamp, only reset accepted.
// - Panel reset clears panel and indications.
// - Already active: status, entered, code; clear only.
// - Not active: status, pending, code, panel dark.
// - Up to nine pending faults held.
// - Select then enter activates slot fault.
// - Repeated select and enter activate each.
// - Clear-all inhibits panels until host done.
// - After clear-all all lamps and readouts blank.
// - Slot then fault-clear removes fault, blanks.
// - Slot then display-clear blanks slot only.
// - Time-tagged pending shown before activation.
// - Host pending signal flashes time-tagged lamp.
// - Unanswered time-tagged fault clears at activation.
//
// Our own choices: the APB register port and the register addresses.
module fault_insertion_unit (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [8:0]            slot_sw,
  input  wire logic [4:0]            system_sw,
  input  wire logic                  key_press,
  input  wire logic [2:0]            key_digit,
  input  wire logic                  enter_sw,
  input  wire logic                  fault_clear_sw,
  input  wire logic                  display_clear_sw,
  input  wire logic                  clear_all_sw,
  input  wire logic                  panel_reset_sw,
  output logic      [8:0]            slot_lamp,
  output logic      [4:0]            system_lamp,
  output logic                       in_use_lamp,
  output logic                       invalid_lamp,
  output logic                       clear_all_lamp,
  output logic      [8:0]            verify_readout,
  output logic      [9:0]            status_lamp,
  output logic      [9:0]            entered_lamp,
  output logic      [9:0]            pending_lamp,
  output logic                       time_tagged_lamp,
  output logic      [139:0]          code_readout,
  output logic                       query_req,
  output logic      [13:0]           query_code,
  input  wire logic                  query_ack,
  input  wire logic [1:0]            query_answer,
  output logic                       op_req,
  output logic      [1:0]            op_kind,
  output logic      [13:0]           op_code,
  input  wire logic                  op_ack,
  input  wire logic                  tt_pending,
  input  wire logic [13:0]           tt_code,
  input  wire logic                  tt_activate,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr
);

  localparam int NS = fault_panel_pkg::NUM_SLOTS;
  localparam int TT = fault_panel_pkg::TT_SLOT;

  // Panel switch pins cross from the operator side through two flops.
  logic [22:0] pin_s1_ff;
  logic [22:0] pin_s2_ff;
  logic [22:0] pin_s3_ff;
  logic [22:0] pin_raw;
  logic [22:0] pin_rise;
  assign pin_raw = {slot_sw, system_sw, key_press, key_digit, enter_sw,
                    fault_clear_sw, display_clear_sw, clear_all_sw,
                    panel_reset_sw};

  always_ff @(posedge mclk) begin
    pin_s1_ff <= pin_raw;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
  end

  // Presses are rising edges on the synchronised levels; the digit is a level.
  assign pin_rise = pin_s2_ff & ~pin_s3_ff;
  wire [8:0] slot_press   = pin_rise[22:14];
  wire [4:0] sys_press    = pin_rise[13:9];
  wire       key_ev       = pin_rise[8];
  wire [2:0] digit_now    = pin_s2_ff[7:5];
  wire       enter_ev     = pin_rise[4];
  wire       fclr_ev      = pin_rise[3];
  wire       dclr_ev      = pin_rise[2];
  wire       clrall_ev    = pin_rise[1];
  wire       sw_reset_ev  = pin_rise[0];

  // Register bus: write CTRL bit 0 acts as a panel reset from software.
  wire apb_wr = psel && penable && pwrite;
  wire sw_ctl_reset = apb_wr && (paddr == fault_panel_pkg::OFS_CTRL) &&
                      pwdata[0] == fault_panel_pkg::CTRL_RST;
  wire panel_rst_ev = sw_reset_ev || sw_ctl_reset;

  fault_panel_pkg::state_t state_ff;
  fault_panel_pkg::state_t nxt_state;
  logic [3:0]  slot_ff;
  logic [4:0]  sys_ff;
  logic [8:0]  digits_ff;
  logic [3:0]  dcount_ff;
  logic [1:0]  opk_ff;
  logic [9:0]  pend_ff;
  logic [9:0]  entd_ff;
  logic [9:0]  stat_ff;
  logic [13:0] code_mem_ff [0:9];
  logic        tt_flag_ff;
  logic        flash_ff;
  logic [27:0] flash_cnt_ff;

  wire       any_slot  = |slot_press;
  wire       any_sys   = |sys_press;
  wire [13:0] cur_code = {sys_ff, digits_ff};
  logic [3:0] slot_idx;

  // Encode the pressed slot; slot ten has no switch and cannot be chosen.
  always_comb begin
    slot_idx = 4'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (slot_press[i]) begin
        slot_idx = 4'(i);
      end
    end
  end

  // Panel sequencer; an out-of-order press trips the invalid state.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fault_panel_pkg::ST_IDLE: begin
        // Only the synchronised edge is read; the raw pin is never sampled.
        if (clrall_ev) nxt_state = fault_panel_pkg::ST_CLRALL;
        else if (any_slot) nxt_state = fault_panel_pkg::ST_SYSTEM;
        else if (key_ev || enter_ev || fclr_ev || dclr_ev || any_sys) begin
          nxt_state = fault_panel_pkg::ST_INVALID;
        end
      end
      fault_panel_pkg::ST_SYSTEM: begin
        if (any_sys) nxt_state = fault_panel_pkg::ST_DIGITS;
        else if (enter_ev && pend_ff[slot_ff]) begin
          nxt_state = fault_panel_pkg::ST_HOSTOP;
        end else if (fclr_ev && entd_ff[slot_ff]) begin
          nxt_state = fault_panel_pkg::ST_HOSTOP;
        end else if (dclr_ev) nxt_state = fault_panel_pkg::ST_IDLE;
        else if (key_ev || enter_ev || fclr_ev || any_slot) begin
          nxt_state = fault_panel_pkg::ST_INVALID;
        end
      end
      fault_panel_pkg::ST_DIGITS: begin
        if (key_ev && dcount_ff == fault_panel_pkg::DIGITS - 4'h1) begin
          nxt_state = fault_panel_pkg::ST_QUERY;
        end else if (enter_ev || fclr_ev || dclr_ev || any_slot) begin
          nxt_state = fault_panel_pkg::ST_INVALID;
        end
      end
      fault_panel_pkg::ST_QUERY: begin
        if (query_ack) begin
          unique case (query_answer)
            fault_panel_pkg::ANS_ACTIVE: nxt_state = fault_panel_pkg::ST_OPER;
            fault_panel_pkg::ANS_NEW:    nxt_state = fault_panel_pkg::ST_IDLE;
            default:                     nxt_state = fault_panel_pkg::ST_INVALID;
          endcase
        end
      end
      fault_panel_pkg::ST_OPER: begin
        // The slot switch may be pressed again before the clear switch.
        if (fclr_ev) nxt_state = fault_panel_pkg::ST_HOSTOP;
        else if (key_ev || enter_ev || dclr_ev || any_sys) begin
          nxt_state = fault_panel_pkg::ST_INVALID;
        end
      end
      fault_panel_pkg::ST_HOSTOP: begin
        if (op_ack) nxt_state = fault_panel_pkg::ST_IDLE;
      end
      fault_panel_pkg::ST_INVALID: nxt_state = fault_panel_pkg::ST_INVALID;
      fault_panel_pkg::ST_CLRALL: begin
        if (op_ack) nxt_state = fault_panel_pkg::ST_IDLE;
      end
    endcase
    // Panel reset wins everywhere except during a clear-all.
    if (panel_rst_ev && state_ff != fault_panel_pkg::ST_CLRALL) begin
      nxt_state = fault_panel_pkg::ST_IDLE;
    end
  end

  wire in_idle = (state_ff == fault_panel_pkg::ST_IDLE);
  wire ans_ok  = (state_ff == fault_panel_pkg::ST_QUERY) && query_ack;
  wire op_done = (state_ff == fault_panel_pkg::ST_HOSTOP) && op_ack;

  // Panel-side entry registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff  <= fault_panel_pkg::ST_IDLE;
      slot_ff   <= 4'h0;
      sys_ff    <= 5'h00;
      digits_ff <= 9'h000;
      dcount_ff <= 4'h0;
      opk_ff    <= fault_panel_pkg::OP_ACTIVATE;
    end else begin
      state_ff <= nxt_state;
      if (in_idle && any_slot) slot_ff <= slot_idx;
      if (state_ff == fault_panel_pkg::ST_SYSTEM && any_sys) sys_ff <= sys_press;
      if (state_ff == fault_panel_pkg::ST_DIGITS && key_ev) begin
        digits_ff <= {digits_ff[5:0], digit_now};
        dcount_ff <= dcount_ff + 4'h1;
      end
      if (state_ff == fault_panel_pkg::ST_SYSTEM && enter_ev) begin
        opk_ff <= fault_panel_pkg::OP_ACTIVATE;
      end
      if (fclr_ev) opk_ff <= fault_panel_pkg::OP_CLEAR;
      if (nxt_state == fault_panel_pkg::ST_IDLE) begin
        sys_ff    <= 5'h00;
        digits_ff <= 9'h000;
        dcount_ff <= 4'h0;
      end
    end
  end

  // Per-slot display state; host events set, operator actions clear.
  always_ff @(posedge mclk) begin
    if (reset || (state_ff == fault_panel_pkg::ST_CLRALL && op_ack)) begin
      pend_ff <= 10'h000;
      entd_ff <= 10'h000;
      stat_ff <= 10'h000;
      tt_flag_ff <= 1'b0;
    end else begin
      if (ans_ok && query_answer == fault_panel_pkg::ANS_ACTIVE) begin
        stat_ff[slot_ff] <= 1'b1;
        entd_ff[slot_ff] <= 1'b1;
        code_mem_ff[slot_ff] <= cur_code;
      end
      if (ans_ok && query_answer == fault_panel_pkg::ANS_NEW) begin
        stat_ff[slot_ff] <= 1'b1;
        pend_ff[slot_ff] <= 1'b1;
        code_mem_ff[slot_ff] <= cur_code;
      end
      if (op_done && opk_ff == fault_panel_pkg::OP_ACTIVATE) begin
        entd_ff[slot_ff] <= 1'b1;
        pend_ff[slot_ff] <= 1'b0;
      end
      if ((op_done && opk_ff == fault_panel_pkg::OP_CLEAR) ||
          (state_ff == fault_panel_pkg::ST_SYSTEM && dclr_ev)) begin
        entd_ff[slot_ff] <= 1'b0;
        pend_ff[slot_ff] <= 1'b0;
        stat_ff[slot_ff] <= 1'b0;
        code_mem_ff[slot_ff] <= 14'h0000;
      end
      if (tt_pending) begin
        pend_ff[TT] <= 1'b1;
        stat_ff[TT] <= 1'b1;
        tt_flag_ff  <= 1'b1;
        code_mem_ff[TT] <= tt_code;
      end else if (tt_activate && tt_flag_ff) begin
        pend_ff[TT] <= 1'b0;
        stat_ff[TT] <= 1'b0;
        tt_flag_ff  <= 1'b0;
        code_mem_ff[TT] <= 14'h0000;
      end
    end
  end

  // Flash divider for the time-tagged lamp.
  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_cnt_ff <= 28'h0000000;
      flash_ff     <= 1'b0;
    end else if (flash_cnt_ff == 28'(fault_panel_pkg::FLASH_CYC - 1)) begin
      flash_cnt_ff <= 28'h0000000;
      flash_ff     <= ~flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 28'h0000001;
    end
  end

  // Lamp and readout drive.
  // An invalid panel shows only its invalid lamp, not a stale slot choice.
  wire busy = !in_idle && state_ff != fault_panel_pkg::ST_CLRALL &&
              state_ff != fault_panel_pkg::ST_INVALID;
  assign slot_lamp = busy ? (9'h001 << slot_ff) : 9'h000;
  assign system_lamp = busy ? sys_ff : 5'h00;
  assign in_use_lamp = busy;
  assign invalid_lamp = (state_ff == fault_panel_pkg::ST_INVALID);
  assign clear_all_lamp = (state_ff == fault_panel_pkg::ST_CLRALL);
  assign verify_readout = busy ? digits_ff : 9'h000;
  assign status_lamp = stat_ff;
  assign entered_lamp = entd_ff;
  assign pending_lamp = pend_ff;
  assign time_tagged_lamp = tt_flag_ff && flash_ff;
  genvar g;
  for (g = 0; g < 10; g++) begin : g_rd
    assign code_readout[g*14 +: 14] = stat_ff[g] ? code_mem_ff[g] : 14'h0000;
  end

  // Host handshake: requests stand until acknowledged.
  assign query_req  = (state_ff == fault_panel_pkg::ST_QUERY);
  assign query_code = cur_code;
  assign op_req  = (state_ff == fault_panel_pkg::ST_HOSTOP) ||
                   (state_ff == fault_panel_pkg::ST_CLRALL);
  assign op_kind = (state_ff == fault_panel_pkg::ST_CLRALL) ?
                   fault_panel_pkg::OP_CLR_ALL : opk_ff;
  assign op_code = code_mem_ff[slot_ff];

  // APB slave, zero wait states.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    unique case (paddr)
      fault_panel_pkg::OFS_STATUS: prdata = {29'h0, state_ff};
      fault_panel_pkg::OFS_PEND:   prdata = {22'h0, pend_ff};
      fault_panel_pkg::OFS_ENTD:   prdata = {22'h0, entd_ff};
      default:                     prdata = 32'h00000000;
    endcase
  end

  property p_invalid_holds;
    @(posedge mclk) disable iff (reset)
    invalid_lamp && !panel_rst_ev |=> invalid_lamp;
  endproperty
  a_invalid_holds: assert property (p_invalid_holds)
    else $error("Invalid state lost.");

  property p_clrall_blank;
    @(posedge mclk) disable iff (reset)
    clear_all_lamp && op_ack |=> (entered_lamp == 10'h000 && code_readout == '0);
  endproperty
  a_clrall_blank: assert property (p_clrall_blank)
    else $error("Clear-all left lamps.");

  // A slot press in idle opens the panel on the next cycle.
  sequence s_slot_pick;
    in_idle && any_slot && !clrall_ev && !panel_rst_ev;
  endsequence
  property p_slot_pick;
    @(posedge mclk) disable iff (reset)
    s_slot_pick |=> in_use_lamp && slot_lamp != 9'h000;
  endproperty
  a_slot_pick: assert property (p_slot_pick)
    else $error("Slot select lost.");

  // The host query stands, code unchanged, until it is answered.
  property p_query_hold;
    @(posedge mclk) disable iff (reset)
    query_req && !query_ack && !panel_rst_ev |=>
      query_req && $stable(query_code);
  endproperty
  a_query_hold: assert property (p_query_hold)
    else $error("Query dropped early.");

  // A host operation stands, kind unchanged, until it is acknowledged.
  property p_op_hold;
    @(posedge mclk) disable iff (reset)
    op_req && !op_ack && !panel_rst_ev |=> op_req && $stable(op_kind);
  endproperty
  a_op_hold: assert property (p_op_hold)
    else $error("Host operation dropped early.");

  // Clear-all keeps every panel inhibited until the host is done.
  property p_clrall_inhibit;
    @(posedge mclk) disable iff (reset)
    clear_all_lamp && !op_ack |=> clear_all_lamp && !in_use_lamp;
  endproperty
  a_clrall_inhibit: assert property (p_clrall_inhibit)
    else $error("Panel not inhibited in clear-all.");

  // Activation of an unanswered time-tagged fault blanks slot ten.
  property p_tt_clear;
    @(posedge mclk) disable iff (reset)
    tt_activate && tt_flag_ff && !tt_pending |=>
      !time_tagged_lamp && !pending_lamp[TT];
  endproperty
  a_tt_clear: assert property (p_tt_clear)
    else $error("Time-tagged slot not cleared.");

endmodule

// File: host_model.sv
module host_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        query_req,
  input  wire logic [13:0] query_code,
  output logic             query_ack,
  output logic [1:0]       query_answer,
  input  wire logic        op_req,
  input  wire logic [1:0]  op_kind,
  input  wire logic [13:0] op_code,
  output logic             op_ack,
  output logic             tt_pending,
  output logic [13:0]      tt_code,
  output logic             tt_activate
);
  timeunit 1ns;
  timeprecision 1ps;
  bit          act[bit [13:0]];
  int          wait_cyc = 1;
  int          cnt = 0;
  logic [13:0] tt_val;

  // Idle answer lines toggle so a stale value can never pass for a reply.
  initial begin
    {query_ack, op_ack, tt_pending, tt_activate} = '0;
    query_answer = 2'h3;
    tt_val = 14'h0;
  end
  assign tt_code = (tt_pending || tt_activate) ? tt_val : ~tt_val;

  // Codes whose digits are all sevens are unknown to the host.
  always @(posedge mclk) begin
    query_ack <= 1'b0;
    op_ack <= 1'b0;
    query_answer <= ~query_answer;
    if (reset || !(query_req || op_req) || query_ack || op_ack) begin
      cnt <= 0;
    end else if (cnt < wait_cyc) begin
      cnt <= cnt + 1;
    end else if (query_req) begin
      query_ack <= 1'b1;
      query_answer <= (query_code[8:0] == 9'h1FF) ?
        fault_panel_pkg::ANS_INVALID : act.exists(query_code) ?
        fault_panel_pkg::ANS_ACTIVE : fault_panel_pkg::ANS_NEW;
    end else begin
      op_ack <= 1'b1;
      case (op_kind)
        fault_panel_pkg::OP_ACTIVATE: act[op_code] = 1'b1;
        fault_panel_pkg::OP_CLEAR: act.delete(op_code);
        default: act.delete();
      endcase
    end
  end

  // Time-tagged warning or activation, one pulse with its code.
  task automatic send_tt(input logic a, input logic [13:0] c);
    @(posedge mclk);
    tt_val <= c;
    tt_pending <= ~a;
    tt_activate <= a;
    @(posedge mclk);
    tt_pending <= 1'b0;
    tt_activate <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk = 1'b0, reset = 1'b1;
  logic [8:0]   slot_sw = 9'h000, slot_lamp, verify_readout;
  logic [4:0]   system_sw = 5'h00, system_lamp;
  logic [2:0]   key_digit = 3'h0;
  logic         key_press = 1'b0, enter_sw = 1'b0, fault_clear_sw = 1'b0;
  logic         display_clear_sw = 1'b0, clear_all_sw = 1'b0;
  logic         panel_reset_sw = 1'b0, psel = 1'b0, penable = 1'b0;
  logic         pwrite = 1'b0, in_use_lamp, invalid_lamp, clear_all_lamp;
  logic         time_tagged_lamp, query_req, query_ack, op_req, op_ack;
  logic         tt_pending, tt_activate, pready, pslverr, re;
  logic [9:0]   status_lamp, entered_lamp, pending_lamp;
  logic [139:0] code_readout;
  logic [13:0]  query_code, op_code, tt_code;
  logic [1:0]   query_answer, op_kind;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  int           errors = 0, num_checks = 0;

  fault_insertion_unit i_fault_insertion_unit (.*);
  host_model i_host_model (.*);

  always #2 mclk = ~mclk;

  task automatic chk(input logic [139:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Presses outlast the input synchronizers before the switch is let go.
  task automatic sw(input int k, input logic [8:0] v);
    @(posedge mclk);
    case (k)
      0: slot_sw <= v;
      1: system_sw <= v[4:0];
      2: begin
        key_digit <= v[2:0];
        key_press <= 1'b1;
      end
      3: enter_sw <= 1'b1;
      4: fault_clear_sw <= 1'b1;
      5: display_clear_sw <= 1'b1;
      6: clear_all_sw <= 1'b1;
      default: panel_reset_sw <= 1'b1;
    endcase
    repeat (5) @(posedge mclk);
    {slot_sw, system_sw, key_press, enter_sw} <= '0;
    {fault_clear_sw, display_clear_sw, clear_all_sw, panel_reset_sw} <= '0;
    repeat (8) @(posedge mclk);
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic enter_code(input int s, input logic [4:0] y,
                            input logic [8:0] dg);
    sw(0, 9'h001 << s);
    chk(slot_lamp, 9'h001 << s, "slot lamp");
    chk(in_use_lamp, 1'b1, "in use");
    sw(1, {4'h0, y});
    chk(system_lamp, y, "system lamp");
    for (int i = 2; i >= 0; i--) begin
      sw(2, {6'h00, dg[3*i +: 3]});
      if (i > 0) chk(verify_readout, dg >> (3*i), "verify");
    end
  endtask

  task automatic t_idle;
    chk({status_lamp, entered_lamp, pending_lamp, code_readout}, '0, "rst");
    apb(1'b0, fault_panel_pkg::OFS_STATUS, 32'h0);
    chk(rd, {29'h0, fault_panel_pkg::ST_IDLE}, "idle");
    $display("Test done: idle");
  endtask

  task automatic t_new;
    enter_code(0, 5'h01, 9'h053);
    chk(pending_lamp, 10'h001, "pending");
    chk(status_lamp, 10'h001, "status");
    chk({slot_lamp, system_lamp, in_use_lamp}, '0, "panel dark");
    enter_code(1, 5'h02, 9'h0A6);
    chk(code_readout, {112'h0, 14'h04A6, 14'h0253}, "codes");
    apb(1'b0, fault_panel_pkg::OFS_PEND, 32'h0);
    chk(rd, 32'h3, "pending reg");
    $display("Test done: new codes");
  endtask

  task automatic t_activate;
    sw(0, 9'h001);
    sw(3, 9'h0);
    chk({entered_lamp, pending_lamp}, {10'h001, 10'h002}, "act 1");
    chk(in_use_lamp, 1'b0, "in use off");
    sw(0, 9'h002);
    sw(3, 9'h0);
    chk({entered_lamp, pending_lamp}, {10'h003, 10'h000}, "act 2");
    chk(i_host_model.act.size(), 2, "host list");
    apb(1'b0, fault_panel_pkg::OFS_ENTD, 32'h0);
    chk(rd, 32'h3, "entered reg");
    $display("Test done: activate");
  endtask

  task automatic t_clear_one;
    enter_code(2, 5'h01, 9'h053);
    chk({status_lamp[2], entered_lamp[2]}, 2'h3, "already");
    chk(code_readout[41:28], 14'h0253, "already code");
    sw(0, 9'h004);
    sw(4, 9'h0);
    chk({status_lamp[2], entered_lamp[2]}, 2'h0, "cleared");
    chk(code_readout[41:28], 14'h0, "blank");
    chk(i_host_model.act.exists(14'h0253), 0, "host clear");
    sw(0, 9'h002);
    sw(5, 9'h0);
    chk({status_lamp[1], entered_lamp[1]}, 2'h0, "disp off");
    chk(code_readout[27:14], 14'h0, "disp blank");
    chk(i_host_model.act.exists(14'h04A6), 1, "host kept");
    $display("Test done: clears");
  endtask

  task automatic t_invalid;
    sw(3, 9'h0);
    chk(invalid_lamp, 1'b1, "bad order");
    sw(0, 9'h001);
    chk(slot_lamp, 9'h000, "ignored");
    sw(7, 9'h0);
    chk({invalid_lamp, slot_lamp}, '0, "panel reset");
    enter_code(3, 5'h04, 9'h1FF);
    chk(invalid_lamp, 1'b1, "bad code");
    apb(1'b1, fault_panel_pkg::OFS_CTRL, 32'h1);
    @(posedge mclk);
    chk(invalid_lamp, 1'b0, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd, re}, 33'h0, "unmapped");
    $display("Test done: invalid");
  endtask

  task automatic t_time_tag;
    i_host_model.send_tt(1'b0, 14'h0C01);
    chk(pending_lamp[9], 1'b1, "tt pending");
    chk(code_readout[139:126], 14'h0C01, "tt code");
    i_host_model.send_tt(1'b1, 14'h0C01);
    chk({time_tagged_lamp, pending_lamp[9]}, 2'h0, "tt done");
    chk(code_readout[139:126], 14'h0, "tt blank");
    $display("Test done: time tag");
  endtask

  task automatic t_clear_all;
    int n;
    n = 0;
    i_host_model.wait_cyc = 60;
    sw(6, 9'h0);
    chk(clear_all_lamp, 1'b1, "clr busy");
    sw(0, 9'h001);
    chk(slot_lamp, 9'h000, "inhibited");
    while (clear_all_lamp !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk(clear_all_lamp, 1'b0, "clr done");
    chk({status_lamp, entered_lamp, pending_lamp}, '0, "dark");
    chk(code_readout, '0, "blank all");
    chk(i_host_model.act.size(), 0, "host empty");
    i_host_model.wait_cyc = 1;
    $display("Test done: clear all");
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles needed.
  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_idle();
    t_new();
    t_activate();
    t_clear_one();
    t_invalid();
    t_time_tag();
    t_clear_all();
    print_verdict();
  end
endmodule
